/* File: include/icec_defs.svh */
`ifndef ICEC_DEFS_SVH
`define ICEC_DEFS_SVH

// channel count and clock rate
`define ICEC_CHANNELS     16
`define ICEC_CLK_MHZ      250

// filter step lengths and watchdog unit in their own units
`define ICEC_STEP_US      1000
`define ICEC_HALF_STEP_US 500
`define ICEC_WD_UNIT_MS   1000

// register byte offsets
`define ICEC_OFS_CTRL     12'h000
`define ICEC_OFS_WDOG     12'h004
`define ICEC_OFS_RUN      12'h008
`define ICEC_OFS_CLEAR    12'h00c
`define ICEC_OFS_LEVEL    12'h010
`define ICEC_OFS_CFG      12'h040
`define ICEC_OFS_COUNT    12'h080

// control register bit positions
`define ICEC_CTRL_COMMIT  0
`define ICEC_CTRL_RESTART 1
`define ICEC_CTRL_FBACK   2

// channel config field positions
`define ICEC_CFG_COUNTER  0
`define ICEC_CFG_RISE     1
`define ICEC_CFG_FALL     2
`define ICEC_CFG_BOOT     3
`define ICEC_CFG_FBL      4
`define ICEC_CFG_RUNSEL   5
`define ICEC_CFG_RETAIN   6
`define ICEC_CFG_FLT_LSB  16

// reset values
`define ICEC_RST_FILTER   16'h0064
`define ICEC_RST_WDOG     16'h0000

`endif

/* File: include/icec_pkg.sv */
package icec_pkg;

	// per-channel configuration as software sees it
	typedef struct packed {
		logic [15:0] filter;
		logic        retain;
		logic        run_sel;
		logic        fb_launch;
		logic        boot_launch;
		logic        fall_sel;
		logic        rise_sel;
		logic        counter_mode;
	} icec_cfg_s;

	// ahb-lite data phase answer
	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} icec_ans_s;

	typedef logic [31:0] icec_cnt_t;

endpackage

/* File: design/icec_top.sv */
`include "icec_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module icec_top #(
	parameter int unsigned STEP_CYC = `ICEC_STEP_US * `ICEC_CLK_MHZ,
	parameter int unsigned HALF_CYC = `ICEC_HALF_STEP_US * `ICEC_CLK_MHZ,
	parameter int unsigned SEC_CYC  = `ICEC_WD_UNIT_MS * 1000 * `ICEC_CLK_MHZ,
	parameter logic [15:0] HALF_MASK = 16'h0000
) (
	input  wire logic              hclk,              // system clock
	input  wire logic              hresetn,           // async reset, low
	input  wire logic              hsel,              // slave select
	input  wire logic [11:0]       haddr,             // byte address
	input  wire logic [1:0]        htrans,            // transfer type
	input  wire logic              hwrite,            // write when high
	input  wire logic [2:0]        hsize,             // word only
	input  wire logic [31:0]       hwdata,            // write data
	input  wire logic              hready,            // bus ready
	output icec_pkg::icec_ans_s    ans,               // rdata, ready, resp
	input  wire logic [15:0]       sensed_input_line, // raw field inputs
	input  wire logic              store_valid,       // retained store ok
	output logic [15:0]            level_out,         // filtered levels
	output logic                   fallback_out       // fallback state
);
	import icec_pkg::*;

	localparam int NCH = `ICEC_CHANNELS;

	// configuration and state
	icec_cfg_s   cfg_reg [NCH];
	icec_cnt_t   cnt_reg [NCH];
	logic [15:0] flt_cnt_reg [NCH];
	logic [15:0] run_reg, clr_req_reg, lvl_reg;
	logic [15:0] in_s1_reg, in_s2_reg;
	logic [15:0] wd_limit_reg, wd_secs_reg;
	logic [31:0] sec_cnt_reg, ms_cnt_reg, half_cnt_reg;
	logic        fallback_reg;
	logic [1:0]  pu_cnt_reg;
	logic        pu_done_reg;
	icec_ans_s   ans_reg;
	// bus data phase capture
	logic        wr_pend_reg;
	logic [11:0] wr_addr_reg;
	// retained store: no reset, written only once up
	icec_cnt_t   keep_cnt [NCH];
	logic [15:0] keep_flag;

	// bus decode
	wire access   = hsel & htrans[1] & hready;
	wire rd_take  = access & ~hwrite;
	wire wr_take  = access & hwrite;
	wire wr_ctrl  = wr_pend_reg & (wr_addr_reg == `ICEC_OFS_CTRL);
	wire wr_wdog  = wr_pend_reg & (wr_addr_reg == `ICEC_OFS_WDOG);
	wire wr_run   = wr_pend_reg & (wr_addr_reg == `ICEC_OFS_RUN);
	wire wr_clear = wr_pend_reg & (wr_addr_reg == `ICEC_OFS_CLEAR);
	wire commit   = wr_ctrl & hwdata[`ICEC_CTRL_COMMIT];
	wire restart  = wr_ctrl & hwdata[`ICEC_CTRL_RESTART];

	// power-on event a few cycles after release, or software restart
	wire pu_evt   = (pu_cnt_reg == 2'd2) | restart;
	wire restore  = pu_cnt_reg == 2'd2;

	// decode of a channel config or count word
	function automatic logic hit_bank(input logic [11:0] a,
	                                  input logic [11:0] base);
		hit_bank = (a[11:6] == base[11:6]) & (a[1:0] == 2'b00);
	endfunction

	function automatic logic [31:0] cfg_word(input icec_cfg_s c);
		cfg_word = {c.filter, 9'h000, c.retain, c.run_sel, c.fb_launch,
		            c.boot_launch, c.fall_sel, c.rise_sel, c.counter_mode};
	endfunction

	function automatic icec_cfg_s word_cfg(input logic [31:0] w);
		word_cfg.filter       = w[`ICEC_CFG_FLT_LSB +: 16];
		word_cfg.retain       = w[`ICEC_CFG_RETAIN];
		word_cfg.run_sel      = w[`ICEC_CFG_RUNSEL];
		word_cfg.fb_launch    = w[`ICEC_CFG_FBL];
		word_cfg.boot_launch  = w[`ICEC_CFG_BOOT];
		word_cfg.fall_sel     = w[`ICEC_CFG_FALL];
		word_cfg.rise_sel     = w[`ICEC_CFG_RISE];
		word_cfg.counter_mode = w[`ICEC_CFG_COUNTER];
	endfunction

	// read mux, evaluated in the address phase
	wire [3:0] rd_ch = haddr[5:2];
	wire [31:0] rd_word =
		(haddr == `ICEC_OFS_CTRL)  ? {29'h0, fallback_reg, 2'b00} :
		(haddr == `ICEC_OFS_WDOG)  ? {16'h0, wd_limit_reg} :
		(haddr == `ICEC_OFS_RUN)   ? {16'h0, run_reg} :
		(haddr == `ICEC_OFS_CLEAR) ? {16'h0, clr_req_reg} :
		(haddr == `ICEC_OFS_LEVEL) ? {16'h0, lvl_reg} :
		hit_bank(haddr, `ICEC_OFS_CFG)   ? cfg_word(cfg_reg[rd_ch]) :
		hit_bank(haddr, `ICEC_OFS_COUNT) ? cnt_reg[rd_ch] : 32'h0;

	// bus slave: zero wait, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ans_reg     <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else begin
			ans_reg.hrdata <= rd_take ? rd_word : 32'h0;
			wr_pend_reg    <= wr_take;
			wr_addr_reg    <= haddr;
		end
	end

	// time bases for filter steps and watchdog seconds
	wire ms_tick   = ms_cnt_reg == STEP_CYC - 1;
	wire half_tick = half_cnt_reg == HALF_CYC - 1;
	wire sec_tick  = sec_cnt_reg == SEC_CYC - 1;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_cnt_reg   <= 32'h0;
			half_cnt_reg <= 32'h0;
			sec_cnt_reg  <= 32'h0;
		end else begin
			ms_cnt_reg   <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
			half_cnt_reg <= half_tick ? 32'h0 : half_cnt_reg + 32'h1;
			sec_cnt_reg  <= (sec_tick | access) ? 32'h0 : sec_cnt_reg + 32'h1;
		end
	end

	// watchdog: only way into fallback, off while limit is zero
	wire wd_on    = wd_limit_reg != 16'h0;
	wire fb_entry = wd_on & ~fallback_reg & ~access &
	                (wd_secs_reg >= wd_limit_reg);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_limit_reg <= `ICEC_RST_WDOG;
			wd_secs_reg  <= 16'h0;
			fallback_reg <= 1'b0;
		end else begin
			if (wr_wdog)
				wd_limit_reg <= hwdata[15:0];
			if (access)
				wd_secs_reg <= 16'h0;
			else if (sec_tick && wd_secs_reg != 16'hffff)
				wd_secs_reg <= wd_secs_reg + 16'h1;
			if (access)
				fallback_reg <= 1'b0;
			else if (fb_entry)
				fallback_reg <= 1'b1;
		end
	end

	// input synchroniser and power-up sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_s1_reg   <= 16'h0;
			in_s2_reg   <= 16'h0;
			pu_cnt_reg  <= 2'd0;
			pu_done_reg <= 1'b0;
		end else begin
			in_s1_reg <= sensed_input_line;
			in_s2_reg <= in_s1_reg;
			if (pu_cnt_reg != 2'd3)
				pu_cnt_reg <= pu_cnt_reg + 2'd1;
			pu_done_reg <= pu_cnt_reg == 2'd3;
		end
	end

	// clear requests are held until a commit uses them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			clr_req_reg <= 16'h0;
		else if (commit)
			clr_req_reg <= 16'h0;
		else if (wr_clear)
			clr_req_reg <= hwdata[15:0];
	end

	logic [15:0] flt_hit, inc, zero_flt, clr_hit, run_next;

	for (genvar g = 0; g < NCH; g++) begin : gen_ch
		wire [15:0] flt      = cfg_reg[g].filter;
		wire        flt_tick = HALF_MASK[g] ? half_tick : ms_tick;
		wire        differ   = in_s2_reg[g] != lvl_reg[g];
		wire        wr_cfg   = wr_pend_reg &
		                       hit_bank(wr_addr_reg, `ICEC_OFS_CFG) &
		                       (wr_addr_reg[5:2] == 4'(g));
		wire        rise     = flt_hit[g] & ~lvl_reg[g];
		wire        fall     = flt_hit[g] & lvl_reg[g];
		wire        neither  = ~cfg_reg[g].boot_launch &
		                       ~cfg_reg[g].fb_launch;
		// a zero filter written now stops the run on that same edge
		wire        stop_now = wr_cfg ?
		                       (hwdata[`ICEC_CFG_FLT_LSB +: 16] == 16'h0) :
		                       zero_flt[g];
		// level moves only after a full filter span
		assign flt_hit[g] = differ & ((flt == 16'h0) |
		                    (flt_tick & (flt_cnt_reg[g] + 16'h1 >= flt)));
		assign zero_flt[g] = flt == 16'h0;
		assign clr_hit[g]  = commit & clr_req_reg[g];
		// qualified edge of the filtered level
		assign inc[g] = run_reg[g] & cfg_reg[g].counter_mode &
		                ((rise & cfg_reg[g].rise_sel) |
		                 (fall & cfg_reg[g].fall_sel));
		// run state: zero filter, launch events, then host command
		assign run_next[g] =
			stop_now      ? 1'b0 :
			pu_evt        ? cfg_reg[g].boot_launch :
			fb_entry      ? (cfg_reg[g].fb_launch |
			                 (run_reg[g] &
			                  ~(neither & cfg_reg[g].run_sel))) :
			wr_run        ? hwdata[g] :
			run_reg[g];

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				cfg_reg[g]     <= '{filter: `ICEC_RST_FILTER, default: 1'b0};
				cnt_reg[g]     <= 32'h0;
				flt_cnt_reg[g] <= 16'h0;
				lvl_reg[g]     <= 1'b0;
				run_reg[g]     <= 1'b0;
			end else begin
				if (wr_cfg)
					cfg_reg[g] <= word_cfg(hwdata);
				flt_cnt_reg[g] <= (!differ || flt_hit[g]) ? 16'h0 :
				                  flt_tick ? flt_cnt_reg[g] + 16'h1 :
				                  flt_cnt_reg[g];
				if (flt_hit[g])
					lvl_reg[g] <= in_s2_reg[g];
				run_reg[g] <= run_next[g];
				if (clr_hit[g])
					cnt_reg[g] <= 32'h0;
				else if (restore && store_valid && keep_flag[g])
					cnt_reg[g] <= keep_cnt[g];
				else if (inc[g])
					cnt_reg[g] <= cnt_reg[g] + 32'h1;
			end
		end

		// retained copy, not touched by reset or before power-up ends
		always_ff @(posedge hclk) begin
			if (pu_done_reg) begin
				keep_cnt[g]  <= cnt_reg[g];
				keep_flag[g] <= cfg_reg[g].retain;
			end
		end
	end

	// outputs straight from flops
	assign ans          = ans_reg;
	assign level_out    = lvl_reg;
	assign fallback_out = fallback_reg;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_zero_filter_idle: assert property (
		(run_reg & zero_flt) == 16'h0)
		else $error("counter runs with zero filter");
	a_edge_only_qualified: assert property (
		inc[0] |-> cfg_reg[0].counter_mode &&
		((cfg_reg[0].rise_sel && !lvl_reg[0]) ||
		 (cfg_reg[0].fall_sel && lvl_reg[0])))
		else $error("count on unselected edge");
	a_count_step_one: assert property (
		!clr_hit[0] && !restore |=>
		cnt_reg[0] == $past(cnt_reg[0]) + 32'($past(inc[0])))
		else $error("count moved by other than one");
	a_clear_zeroes: assert property (
		clr_hit[0] |=> cnt_reg[0] == 32'h0 && clr_req_reg == 16'h0)
		else $error("commit did not clear count");
	a_boot_launch_run: assert property (
		pu_evt && cfg_reg[0].boot_launch && !gen_ch[0].stop_now |=> run_reg[0])
		else $error("boot launch did not start");
	a_fallback_launch: assert property (
		fb_entry && cfg_reg[0].fb_launch && !gen_ch[0].stop_now && !pu_evt
		|=> run_reg[0] && fallback_reg)
		else $error("fallback launch did not start");
	a_runsel_halt: assert property (
		(pu_evt || fb_entry) && cfg_reg[0].run_sel &&
		!cfg_reg[0].boot_launch && !cfg_reg[0].fb_launch |=> !run_reg[0])
		else $error("run select not halted");
	a_wdog_off_no_fb: assert property (
		!wd_on && !fallback_reg && !wr_wdog |=> !fallback_reg)
		else $error("fallback with watchdog off");
	a_host_start: assert property (
		wr_run && hwdata[0] && !zero_flt[0] && !pu_evt && !fb_entry
		|=> run_reg[0])
		else $error("host start ignored");
	a_level_filtered: assert property (
		lvl_reg[0] != $past(lvl_reg[0]) |-> $past(flt_hit[0]))
		else $error("level moved before filter span");

	// counting, filter, retention, fallback and bus checks
	a_level_mode_hold: assert property (
		!cfg_reg[0].counter_mode && !clr_hit[0] && !restore
		|=> $stable(cnt_reg[0]))
		else $error("count moved in level mode");
	a_stopped_hold: assert property (
		!run_reg[0] && !clr_hit[0] && !restore
		|=> $stable(cnt_reg[0]))
		else $error("stopped counter moved");
	a_filter_step_ms: assert property (
		flt_hit[0] && !zero_flt[0]
		|-> (HALF_MASK[0] ? half_tick : ms_tick))
		else $error("level moved off a step tick");
	a_filter_step_half: assert property (
		flt_hit[2] && !zero_flt[2]
		|-> (HALF_MASK[2] ? half_tick : ms_tick))
		else $error("half step level moved off tick");
	a_restore_count: assert property (
		restore && store_valid && keep_flag[0] && !clr_hit[0]
		|=> cnt_reg[0] == $past(keep_cnt[0]))
		else $error("retained count not restored");
	a_clear_request: assert property (
		wr_clear && !commit
		|=> clr_req_reg == $past(hwdata[15:0]))
		else $error("clear request not held");
	a_fb_launch_waits: assert property (
		pu_evt && cfg_reg[0].fb_launch && !cfg_reg[0].boot_launch
		|=> !run_reg[0])
		else $error("fallback launch ran at power-on");
	a_fallback_exit: assert property (
		access |=> !fallback_reg)
		else $error("fallback kept after host access");
	a_bus_okay: assert property (
		ans_reg.hreadyout && !ans_reg.hresp)
		else $error("bus answer not ready and okay");

	c_count_rise:  cover property (inc[0] && !lvl_reg[0]);
	c_fallback_in: cover property (fb_entry ##1 fallback_reg);
	c_clear_count: cover property (clr_hit[0] && cnt_reg[0] != 32'h0);
	c_restore:     cover property (restore && store_valid && keep_flag[0]);
	c_half_step:   cover property (flt_hit[2] && half_tick);

endmodule

`default_nettype wire

/* File: tb/icec_field_model.sv */
`timescale 1ns/100ps
`default_nettype none

// dry or wet contacts: every change chatters before it settles
module icec_field_model (
	input  wire logic        hclk,              // sampling clock
	input  wire logic [15:0] target,            // commanded contact level
	output logic      [15:0] sensed_input_line  // levels seen by the unit
);
	logic [15:0] settled_reg = 16'h0000; // level the contacts settle to
	logic [15:0] moving_reg  = 16'h0000; // lines still chattering
	logic [1:0]  bounce_reg  = 2'h0;     // chatter cycles left

	// chatter lasts less than one filter step, then the level settles
	always_ff @(posedge hclk) begin
		if (target != settled_reg) begin
			moving_reg  <= target ^ settled_reg;
			settled_reg <= target;
			bounce_reg  <= 2'h3;
		end else if (bounce_reg != 2'h0) begin
			bounce_reg <= bounce_reg - 2'h1;
		end
	end

	// odd cycles show the old level on moving lines
	assign sensed_input_line = settled_reg
		^ (moving_reg & {16{bounce_reg[0]}});
endmodule

`default_nettype wire

/* File: tb/input_channel_event_counter_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module input_channel_event_counter_tb;
	import icec_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, store_valid, rd_phase;
	logic        fallback_out;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [15:0] target, sensed_input_line, level_out;
	icec_ans_s   ans;
	int          n_mismatch, tests_run, seed, n;
	logic [31:0] exp_q[$];
	string       nm_q[$];

	// short counts: step 4 cycles, half step 2, second 20
	icec_top #(.STEP_CYC(4), .HALF_CYC(2), .SEC_CYC(20),
		.HALF_MASK(16'h0004)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(ans.hreadyout), .ans(ans),
		.sensed_input_line(sensed_input_line),
		.store_valid(store_valid), .level_out(level_out),
		.fallback_out(fallback_out));

	icec_field_model field (.hclk(hclk), .target(target),
		.sensed_input_line(sensed_input_line));

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one single ahb-lite word transfer, waiting on hready each phase
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (ans.hreadyout !== 1'b1);
		hsel     <= 1'b0;
		htrans   <= 2'b00;
		hwdata   <= d;
		rd_phase <= ~wr;
		do @(posedge hclk); while (ans.hreadyout !== 1'b1);
		rd_phase <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// note the expected word, the monitor compares it
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		bus(1'b0, a, 32'h0);
	endtask

	// read data taken at the edge closing the data phase
	always @(posedge hclk) begin
		if (rd_phase === 1'b1) begin
			check(nm_q.pop_front(), ans.hrdata, exp_q.pop_front());
			check("hresp", ans.hresp, 32'h0);
		end
	end

	// one high pulse on the masked contacts
	task automatic pulse(input logic [15:0] m);
		target <= target | m;
		repeat (8) @(posedge hclk);
		#1 check("level early", level_out & m & 16'hff77, 32'h0);
		repeat (2) @(posedge hclk);
		#1 check("half", level_out & m & 16'hfff7, {16'h0, m & 16'h4});
		repeat (20) @(posedge hclk);
		#1 check("level high", level_out & m, {16'h0, m});
		@(posedge hclk);
		target <= target & ~m;
		repeat (29) @(posedge hclk);
	endtask

	// power loss in mid-run, the store flagged valid or not
	task automatic power_cycle(input logic valid);
		@(posedge hclk);
		store_valid <= valid;
		hresetn     <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask

	// watchdog against a hang
	initial begin
		repeat (8000) @(posedge hclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		seed = 63;
		n_mismatch = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		store_valid = 1'b1;
		rd_phase = 1'b0;
		target = 16'h0000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		rd("cfg0", 12'h040, 32'h0064_0000);
		rd("wdog", 12'h004, 32'h0);
		rd("hole", 12'h020 | (12'($random(seed)) & 12'h01c), 32'h0);
		wr(12'h040, 32'h0002_0043);
		wr(12'h044, 32'h0002_0005);
		wr(12'h048, 32'h0002_0007);
		wr(12'h04c, 32'h0000_0001);
		wr(12'h05c, 32'h0002_0000);
		wr(12'h008, 32'h0000_000f);
		rd("run", 12'h008, 32'h0000_0007);
		n = 1 + ($random(seed) & 3);
		repeat (n) pulse(16'h008f);
		rd("count0", 12'h080, 32'(n));
		rd("count1", 12'h084, 32'(n));
		rd("count2", 12'h088, 32'(2 * n));
		rd("count3", 12'h08c, 32'h0);
		rd("count7", 12'h09c, 32'h0);
		wr(12'h008, 32'h0);
		pulse(16'h0001);
		rd("count0 held", 12'h080, 32'(n));
		wr(12'h00c, 32'h0000_0002);
		wr(12'h000, 32'h0000_0001);
		rd("count1 clr", 12'h084, 32'h0);
		rd("count0 kept", 12'h080, 32'(n));
		rd("clear req", 12'h00c, 32'h0);
		power_cycle(1'b1);
		rd("count0 back", 12'h080, 32'(n));
		rd("count2 lost", 12'h088, 32'h0);
		wr(12'h050, 32'h0002_0011);
		wr(12'h054, 32'h0002_0021);
		wr(12'h058, 32'h0002_0009);
		wr(12'h008, 32'h0000_0020);
		repeat (60) @(posedge hclk);
		#1 check("fallback idle", fallback_out, 32'h0);
		wr(12'h004, 32'h0000_0001);
		repeat (10) @(posedge hclk);
		#1 check("fallback soon", fallback_out, 32'h0);
		repeat (20) @(posedge hclk);
		#1 check("fallback on", fallback_out, 32'h1);
		rd("run fallback", 12'h008, 32'h0000_0010);
		wr(12'h000, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		rd("run restart", 12'h008, 32'h0000_0040);
		wr(12'h040, 32'h0002_0043);
		power_cycle(1'b0);
		rd("count0 void", 12'h080, 32'h0);
		repeat (2) @(posedge hclk);
		wrap_up();
	end
endmodule

`default_nettype wire
